// >>> fps_pkg.sv
// Purpose: constants and types for the flash sequencing host
// Assumes: 40 MHz aclk, byte-wide flash with command codes
// Notes: Operation
// Operation
// - chip erase: write setup code then confirm code, both 30h
// - chip erase done once toggle bit stops changing
// - block erase starts with setup code 20h
// - confirm code d0h written inside each block to erase
// - successive block loads spaced 0.3 to 30 us apart
// - wait 200 us after last load before toggle checking
// - after block erase check polling bit is 1, then reset
// - hold chip select 6 us before a verify read
// - compatible chip erase: host runs verify and repeat loop; this host only polls the toggle bit
// - compatible block erase acts on one 16 KB block; blocks here are 4 KB (BLK_SHIFT 12)
// - chip select, output enable high while program voltage changes
package fps_pkg;
    localparam int CLK_MHZ = 40;
    localparam int T_WE_PULSE_NS = 50;
    localparam int T_WE_HIGH_NS = 100;
    localparam int T_ACCESS_NS = 120;
    localparam int T_CE_SETUP_NS = 100;
    localparam int T_VPP_SETUP_NS = 100;
    localparam int T_LOAD_SPACING_NS = 300;
    localparam int T_SEL_VERIFY_US = 6;
    localparam int T_SETTLE_US = 200;
    localparam int WE_PULSE_CYC = (T_WE_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int WE_HIGH_CYC = (T_WE_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int ACCESS_CYC = (T_ACCESS_NS * CLK_MHZ + 999) / 1000;
    localparam int CE_SETUP_CYC = (T_CE_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int VPP_SETUP_CYC = (T_VPP_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int SPACING_CYC = (T_LOAD_SPACING_NS * CLK_MHZ + 999) / 1000;
    localparam int SEL_VERIFY_CYC = T_SEL_VERIFY_US * CLK_MHZ;
    localparam int SETTLE_CYC = T_SETTLE_US * CLK_MHZ;
    localparam int SYNC_STAGES = 2;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h30;
    localparam logic [7:0] CMD_BLOCK_SETUP = 8'h20;
    localparam logic [7:0] CMD_BLOCK_CONFIRM = 8'hd0;
    localparam int BLK_SHIFT = 12;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_DATA = 8'h08;
    localparam logic [7:0] REG_MASK = 8'h0c;
    localparam logic [7:0] REG_VPP = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    localparam int CTRL_VERIFY = 3;
    localparam logic [2:0] OP_WRITE = 3'h1;
    localparam logic [2:0] OP_READ = 3'h2;
    localparam logic [2:0] OP_PROG = 3'h3;
    localparam logic [2:0] OP_CHIP = 3'h4;
    localparam logic [2:0] OP_BLOCK = 3'h5;
    typedef enum logic [3:0] {
        ST_IDLE, ST_VPP, ST_BW, ST_BWH, ST_BR_SEL, ST_BR_OE,
        ST_PROG_DATA, ST_CHIP_CONF, ST_SCAN, ST_SPACE, ST_SETTLE,
        ST_POLL_START, ST_POLL_FIRST, ST_POLL_NEXT, ST_RESET_CMD, ST_FINISH
    } fps_st_type;
    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic vpp_en;
        logic [16:0] addr;
        logic [7:0] dq_out;
        logic dq_oe;
    } fps_pins_type;
    localparam fps_pins_type PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1,
        we_n: 1'b1, vpp_en: 1'b0, addr: 17'h0, dq_out: 8'h0, dq_oe: 1'b0};
    typedef struct packed {
        fps_st_type st;
        fps_st_type ret;
        logic [15:0] tmr;
        logic [5:0] idx;
        logic loaded;
        logic [7:0] sync1;
        logic [7:0] sync2;
        logic [7:0] rdata;
        logic [7:0] prev;
        logic [2:0] op;
        logic verify;
        logic start;
        logic [16:0] addr_reg;
        logic [7:0] data_reg;
        logic [31:0] mask_reg;
        logic vpp_req;
        logic busy;
        logic done;
        logic fail;
        fps_pins_type pins;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata_bus;
    } fps_state_type;
endpackage : fps_pkg

// >>> fps_host_ctrl.sv
// Purpose: host sequencer driving a byte-wide flash through its pins
// Assumes: software orders operations over AXI4-Lite registers
// Notes: all state sits in one struct, registered once per edge
`timescale 1ns/1ps
module fps_host_ctrl #(
    parameter int SETTLE_CYCLES = fps_pkg::SETTLE_CYC,
    parameter logic [7:0] CMD_PROGRAM = 8'h10,
    parameter logic [7:0] CMD_RESET = 8'hff
) (
    // clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // axi write
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // flash pins
    output fps_pkg::fps_pins_type flash_pins,
    input wire logic [7:0] flash_dq_in
);
    import fps_pkg::*;

    fps_state_type q;
    fps_state_type nxt;

    function automatic logic [31:0] wmerge(input logic [31:0] old,
            input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction : wmerge

    // open one flash bus cycle, then return to r
    function automatic fps_state_type cyc(input fps_state_type s,
            input logic [16:0] a, input logic [7:0] d,
            input fps_st_type r, input logic rd);
        fps_state_type o;
        o = s;
        o.pins.ce_n = 1'b0;
        o.pins.oe_n = 1'b1;
        o.pins.we_n = rd;
        o.pins.addr = a;
        o.pins.dq_out = d;
        o.pins.dq_oe = !rd;
        o.ret = r;
        o.tmr = 16'h0;
        o.st = rd ? ST_BR_SEL : ST_BW;
        return o;
    endfunction : cyc

    always_comb begin
        logic [15:0] sel_cyc;
        sel_cyc = 16'(CE_SETUP_CYC);
        nxt = q;
        nxt.sync1 = flash_dq_in;
        nxt.sync2 = q.sync1;
        nxt.tmr = q.tmr + 16'h1;
        if (q.verify) begin
            sel_cyc = 16'(SEL_VERIFY_CYC);
        end
        unique case (q.st)
            ST_IDLE: begin
                nxt.tmr = 16'h0;
                if (q.start) begin
                    nxt.start = 1'b0;
                    nxt.busy = 1'b1;
                    nxt.done = 1'b0;
                    nxt.fail = 1'b0;
                    nxt.idx = 6'h0;
                    nxt.loaded = 1'b0;
                    unique case (q.op)
                        OP_WRITE: begin
                            nxt = cyc(nxt, q.addr_reg, q.data_reg,
                                ST_FINISH, 1'b0);
                        end
                        OP_READ: begin
                            nxt = cyc(nxt, q.addr_reg, 8'h0,
                                ST_FINISH, 1'b1);
                        end
                        OP_PROG: begin
                            nxt = cyc(nxt, q.addr_reg, CMD_PROGRAM,
                                ST_PROG_DATA, 1'b0);
                        end
                        OP_CHIP: begin
                            nxt = cyc(nxt, q.addr_reg, CMD_CHIP_ERASE,
                                ST_CHIP_CONF, 1'b0);
                        end
                        OP_BLOCK: begin
                            nxt = cyc(nxt, q.addr_reg, CMD_BLOCK_SETUP,
                                ST_SCAN, 1'b0);
                        end
                        default: begin
                            nxt.fail = 1'b1;
                            nxt.st = ST_FINISH;
                        end
                    endcase
                end else if (q.vpp_req != q.pins.vpp_en) begin
                    nxt.pins = PINS_IDLE;
                    nxt.pins.vpp_en = q.vpp_req;
                    nxt.st = ST_VPP;
                end
            end
            ST_VPP: begin
                if (q.tmr == 16'(VPP_SETUP_CYC - 1)) begin
                    nxt.st = ST_IDLE;
                end
            end
            ST_BW: begin
                if (q.tmr == 16'(WE_PULSE_CYC - 1)) begin
                    nxt.pins.we_n = 1'b1;
                    nxt.pins.ce_n = 1'b1;
                    nxt.tmr = 16'h0;
                    nxt.st = ST_BWH;
                end
            end
            ST_BWH: begin
                nxt.pins.dq_oe = 1'b0;
                if (q.tmr == 16'(WE_HIGH_CYC - 1)) begin
                    nxt.st = q.ret;
                end
            end
            ST_BR_SEL: begin
                if (q.tmr >= sel_cyc - 16'h1) begin
                    nxt.pins.oe_n = 1'b0;
                    nxt.tmr = 16'h0;
                    nxt.st = ST_BR_OE;
                end
            end
            ST_BR_OE: begin
                if (q.tmr == 16'(ACCESS_CYC + SYNC_STAGES - 1)) begin
                    nxt.rdata = q.sync2;
                    nxt.pins.oe_n = 1'b1;
                    nxt.pins.ce_n = 1'b1;
                    nxt.st = q.ret;
                end
            end
            ST_PROG_DATA: begin
                nxt = cyc(nxt, q.addr_reg, q.data_reg,
                    ST_POLL_START, 1'b0);
            end
            ST_CHIP_CONF: begin
                nxt = cyc(nxt, q.addr_reg, CMD_CHIP_ERASE,
                    ST_POLL_START, 1'b0);
            end
            ST_SCAN: begin
                nxt.idx = q.idx + 6'h1;
                if (q.idx[5]) begin
                    nxt.idx = q.idx;
                    nxt.tmr = 16'h0;
                    nxt.fail = !q.loaded;
                    nxt.st = q.loaded ? ST_SETTLE : ST_RESET_CMD;
                end else if (q.mask_reg[q.idx[4:0]]) begin
                    nxt.loaded = 1'b1;
                    nxt = cyc(nxt, 17'(q.idx[4:0]) << BLK_SHIFT,
                        CMD_BLOCK_CONFIRM, ST_SPACE, 1'b0);
                end
            end
            // least spacing, scan keeps it short
            ST_SPACE: begin
                if (q.tmr == 16'(SPACING_CYC - 1)) begin
                    nxt.st = ST_SCAN;
                end
            end
            ST_SETTLE: begin
                if (q.tmr >= SETTLE_CYCLES[15:0] - 16'h1) begin
                    nxt.st = ST_POLL_START;
                end
            end
            ST_POLL_START: begin
                nxt = cyc(nxt, q.addr_reg, 8'h0, ST_POLL_FIRST, 1'b1);
            end
            ST_POLL_FIRST: begin
                nxt.prev = q.rdata;
                nxt = cyc(nxt, q.addr_reg, 8'h0, ST_POLL_NEXT, 1'b1);
            end
            // stop when toggle bit holds still
            ST_POLL_NEXT: begin
                if (q.rdata[TOGGLE_BIT] != q.prev[TOGGLE_BIT]) begin
                    nxt.prev = q.rdata;
                    nxt = cyc(nxt, q.addr_reg, 8'h0, ST_POLL_NEXT, 1'b1);
                end else if (q.op == OP_BLOCK) begin
                    nxt.fail = !q.rdata[POLL_BIT];
                    nxt.st = ST_RESET_CMD;
                end else begin
                    if (q.op == OP_PROG) begin
                        nxt.fail = q.rdata[POLL_BIT] != q.data_reg[POLL_BIT];
                    end
                    nxt.st = ST_FINISH;
                end
            end
            ST_RESET_CMD: begin
                nxt = cyc(nxt, q.addr_reg, CMD_RESET, ST_FINISH, 1'b0);
            end
            ST_FINISH: begin
                nxt.busy = 1'b0;
                nxt.done = 1'b1;
                nxt.verify = 1'b0;
                nxt.st = ST_IDLE;
            end
        endcase

        // axi write channel
        if (q.bvalid && bready) begin
            nxt.bvalid = 1'b0;
        end
        if (q.awready) begin
            nxt.awready = 1'b0;
            nxt.wready = 1'b0;
            nxt.bvalid = 1'b1;
            nxt.bresp = RESP_OKAY;
            unique case (awaddr)
                REG_CTRL: begin
                    // a busy sequencer ignores new orders
                    if (q.st == ST_IDLE && !q.start && wstrb[0]) begin
                        nxt.op = wdata[2:0];
                        nxt.verify = wdata[CTRL_VERIFY];
                        nxt.start = 1'b1;
                    end
                end
                REG_ADDR: begin
                    nxt.addr_reg = 17'(wmerge(32'(q.addr_reg), wdata, wstrb));
                end
                REG_DATA: begin
                    nxt.data_reg = 8'(wmerge(32'(q.data_reg), wdata, wstrb));
                end
                REG_MASK: begin
                    nxt.mask_reg = wmerge(q.mask_reg, wdata, wstrb);
                end
                REG_VPP: begin
                    if (wstrb[0]) begin
                        nxt.vpp_req = wdata[0];
                    end
                end
                REG_STATUS: begin
                end
                default: begin
                    nxt.bresp = RESP_SLVERR;
                end
            endcase
        end else if (awvalid && wvalid && !q.bvalid) begin
            nxt.awready = 1'b1;
            nxt.wready = 1'b1;
        end

        // axi read channel
        if (q.rvalid && rready) begin
            nxt.rvalid = 1'b0;
        end
        if (q.arready) begin
            nxt.arready = 1'b0;
            nxt.rvalid = 1'b1;
            nxt.rresp = RESP_OKAY;
            nxt.rdata_bus = 32'h0;
            unique case (araddr)
                REG_CTRL: begin
                    nxt.rdata_bus = 32'({q.verify, q.op});
                end
                REG_ADDR: begin
                    nxt.rdata_bus = 32'(q.addr_reg);
                end
                REG_DATA: begin
                    nxt.rdata_bus = 32'(q.data_reg);
                end
                REG_MASK: begin
                    nxt.rdata_bus = q.mask_reg;
                end
                REG_VPP: begin
                    nxt.rdata_bus = 32'({q.pins.vpp_en, q.vpp_req});
                end
                REG_STATUS: begin
                    nxt.rdata_bus = 32'({q.rdata, 4'h0, q.pins.vpp_en,
                        q.fail, q.done, q.busy});
                end
                default: begin
                    nxt.rresp = RESP_SLVERR;
                end
            endcase
        end else if (arvalid && !q.rvalid) begin
            nxt.arready = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '{st: ST_IDLE, ret: ST_IDLE, pins: PINS_IDLE,
                default: '0};
        end else if (clk_en) begin
            q <= nxt;
        end
    end

    assign awready = q.awready;
    assign wready = q.wready;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign arready = q.arready;
    assign rvalid = q.rvalid;
    assign rresp = q.rresp;
    assign rdata = q.rdata_bus;
    assign flash_pins = q.pins;
endmodule : fps_host_ctrl

// >>> fps_host_ctrl_props.sv
// Purpose: pin and bus checks for the flash host
// Assumes: synchronous active-low reset on aclk
// Notes: bound to every fps_host_ctrl instance
`timescale 1ns/1ps
module fps_host_ctrl_props #(
    parameter int SETTLE_CYCLES = fps_pkg::SETTLE_CYC
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [31:0] wdata,
    input wire logic bvalid,
    input wire logic arready,
    input wire logic rvalid,
    // flash pins
    input fps_pkg::fps_pins_type flash_pins
);
    import fps_pkg::*;
    logic we_q_ff;
    logic vfy_ff;
    logic [7:0] last_ff;
    logic [10:0] gap_ff;
    logic [15:0] ld_ff;
    logic [8:0] celo_ff;
    wire we_up = flash_pins.we_n && !we_q_ff;
    wire ld_up = we_up && flash_pins.dq_out == CMD_BLOCK_CONFIRM;
    // saturating counters: ce low run, gap between writes, time since load
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            we_q_ff <= 1'b1;
            vfy_ff <= 1'b0;
            last_ff <= 8'h00;
            gap_ff <= 11'h7ff;
            ld_ff <= 16'hffff;
            celo_ff <= 9'h000;
        end else begin
            we_q_ff <= flash_pins.we_n;
            celo_ff <= flash_pins.ce_n ? 9'h000 : celo_ff + {8'h00, celo_ff != 9'h1ff};
            gap_ff <= we_up ? 11'h000 : gap_ff + {10'h000, gap_ff != 11'h7ff};
            ld_ff <= ld_up ? 16'h0000 : ld_ff + {15'h0000, ld_ff != 16'hffff};
            if (we_up) last_ff <= flash_pins.dq_out;
            if (awvalid && awready && awaddr == REG_CTRL) vfy_ff <= wdata[CTRL_VERIFY];
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_idle_reset: assert property (disable iff (1'b0) !aresetn |=> flash_pins.ce_n
        && flash_pins.oe_n && flash_pins.we_n && !flash_pins.vpp_en && !flash_pins.dq_oe)
        else $error("pins not idle after reset");
    a_we_pulse: assert property ($fell(flash_pins.we_n) |-> (!flash_pins.we_n
        && !flash_pins.ce_n && flash_pins.oe_n && flash_pins.dq_oe)[*2] ##1 flash_pins.we_n)
        else $error("command write pulse malformed");
    a_data_hold: assert property ($rose(flash_pins.we_n) |-> flash_pins.ce_n
        && flash_pins.dq_oe && $stable(flash_pins.dq_out) && $stable(flash_pins.addr))
        else $error("data or address moved at write end");
    a_load_addr: assert property (ld_up |-> flash_pins.addr[11:0] == 12'h000)
        else $error("block load not on block base");
    a_load_gap: assert property (ld_up && last_ff == CMD_BLOCK_CONFIRM |->
        gap_ff >= 11'd11 && gap_ff <= 11'd1199) else $error("block load spacing wrong");
    a_settle_wait: assert property ($fell(flash_pins.oe_n) && last_ff == CMD_BLOCK_CONFIRM
        |-> ld_ff >= SETTLE_CYCLES) else $error("poll too soon after last load");
    a_ce_setup: assert property ($fell(flash_pins.oe_n) |-> !flash_pins.ce_n &&
        celo_ff >= (vfy_ff ? SEL_VERIFY_CYC : CE_SETUP_CYC)) else $error("ce setup short");
    a_vpp_quiet: assert property ($changed(flash_pins.vpp_en) |-> flash_pins.ce_n
        && flash_pins.oe_n && $past(flash_pins.ce_n) ##1 (flash_pins.ce_n && flash_pins.oe_n)[*3])
        else $error("vpp moved while selected");
    a_b_answer: assert property (awvalid && awready |=> bvalid)
        else $error("write response late");
    a_r_answer: assert property (arready |=> rvalid) else $error("read data late");
    c_load: cover property (ld_up);
    c_vpp: cover property ($rose(flash_pins.vpp_en));
    c_verify: cover property ($fell(flash_pins.oe_n) && vfy_ff);
endmodule : fps_host_ctrl_props

bind fps_host_ctrl fps_host_ctrl_props #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_props (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .bvalid(bvalid), .arready(arready), .rvalid(rvalid),
    .flash_pins(flash_pins));

// >>> fps_flash_model.sv
// Purpose: behavioural byte-wide flash with embedded program and erase
// Assumes: data wire resolved by the bench from the host dq_oe alone
// Notes: block erase clears the 4 KB region named by the upper address bits
`timescale 1ns/1ps
module fps_flash_model #(
    parameter int PROG_NS = 20000,
    parameter int ERASE_NS = 30000,
    parameter logic [7:0] PROG_CMD = 8'h10
) (
    // host pins
    input fps_pkg::fps_pins_type pins,
    input wire logic [7:0] dq_line,
    // flash data
    output logic [7:0] dq_drv
);
    import fps_pkg::*;
    logic [7:0] mem [0:131071];
    logic [31:0] blk = '0;
    logic [16:0] pa = '0;
    logic [7:0] pd = '0;
    logic [7:0] rd;
    logic [1:0] cst = '0;
    logic [1:0] mode = '0;
    logic busy = 1'b0;
    logic tgl = 1'b0;
    logic sel_w = 1'b0;
    int dur = 0;
    initial begin
        for (int i = 0; i < 131072; i++) mem[i] = 8'hff;
    end
    task start(input logic [1:0] m, input int d);
        mode = m;
        dur = d;
        busy = 1'b1;
    endtask : start
    always @(negedge pins.we_n) begin
        #1;
        sel_w = !pins.ce_n;
    end
    always @(posedge pins.we_n) begin
        if (sel_w && (!busy || cst == 2'd3)) begin
            case (cst)
                2'd0: cst = dq_line == PROG_CMD ? 2'd1 : dq_line == CMD_CHIP_ERASE ? 2'd2 :
                    dq_line == CMD_BLOCK_SETUP ? 2'd3 : 2'd0;
                2'd1: begin
                    pa = pins.addr;
                    pd = dq_line;
                    cst = 2'd0;
                    start(2'd0, PROG_NS);
                end
                2'd2: begin
                    cst = 2'd0;
                    if (dq_line == CMD_CHIP_ERASE) start(2'd1, ERASE_NS);
                end
                default: begin
                    if (dq_line == CMD_BLOCK_CONFIRM) blk[pins.addr[16:12]] = 1'b1;
                    else cst = 2'd0;
                    if (dq_line == CMD_BLOCK_CONFIRM && !busy) start(2'd2, ERASE_NS);
                end
            endcase
        end
    end
    always @(posedge busy) begin
        #(dur);
        for (int i = 0; i < 131072; i++)
            if (mode == 2'd1 || (mode == 2'd2 && blk[i[16:12]])) mem[i] = 8'hff;
        if (mode == 2'd0) mem[pa] = mem[pa] & pd;
        blk = '0;
        busy = 1'b0;
    end
    always @(negedge pins.oe_n) if (busy && !pins.ce_n) tgl = ~tgl;
    always @* begin
        rd = busy ? {mode == 2'd0 ? ~pd[7] : 1'b0, tgl, {6{tgl}} ^ 6'h15} : mem[pins.addr];
        dq_drv = (!pins.ce_n && !pins.oe_n) ? rd : ~rd;
    end
endmodule : fps_flash_model

// >>> fps_host_ctrl_tb_top.sv
// Purpose: register-level regression of the flash host
// Assumes: 40 MHz aclk, flash model on the pins
// Notes: short settle count keeps the run small
`timescale 1ns/1ps
module fps_host_ctrl_tb_top;
    import fps_pkg::*;
    localparam int SETTLE = 50;
    localparam logic [31:0] FM = 32'h0000ff07;
    logic aclk, aresetn, clk_en;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp;
    fps_pins_type flash_pins;
    logic [7:0] flash_dq_in, flash_drv;
    int n_errors = 0;
    int total_checks = 0;
    // shared data wire: host wins while it drives
    assign flash_dq_in = flash_pins.dq_oe ? flash_pins.dq_out : flash_drv;
    fps_host_ctrl #(.SETTLE_CYCLES(SETTLE)) dut (.aclk(aclk), .aresetn(aresetn),
        .clk_en(clk_en), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .flash_pins(flash_pins), .flash_dq_in(flash_dq_in));
    fps_flash_model u_flash (.pins(flash_pins), .dq_line(flash_dq_in), .dq_drv(flash_drv));
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ra, rw, rb;
        logic [1:0] r;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            ra = awready & awvalid;
            rw = wready & wvalid;
            rb = bvalid;
            r = bresp;
            @(posedge aclk);
            if (ra) awvalid <= 1'b0;
            if (rw) wvalid <= 1'b0;
        end while (rb !== 1'b1);
        bready <= 1'b0;
        chk({30'h0, r}, {30'h0, er});
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ra, rv;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            ra = arready & arvalid;
            rv = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ra) arvalid <= 1'b0;
        end while (rv !== 1'b1);
        rready <= 1'b0;
    endtask : rd
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
        input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk({30'h0, r}, {30'h0, er});
        chk(d & m, e);
    endtask : rchk
    // start an operation, then poll status until idle
    task automatic op(input logic [31:0] c, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] s;
        logic [1:0] r;
        int n;
        n = 0;
        wr(REG_CTRL, c, RESP_OKAY);
        do begin
            rd(REG_STATUS, s, r);
            n++;
        end while (s[0] !== 1'b0 && n < 3000);
        chk(s & m, e);
    endtask : op
    function automatic logic [31:0] st(input logic [7:0] b, input logic f);
        return {16'h0, b, 5'h0, f, 2'b10};
    endfunction : st
    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (40000) @(posedge aclk);
        n_errors++;
        give_verdict();
    end
    initial begin
        {aresetn, awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
        clk_en = 1'b1;
        wstrb = 4'hf;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(REG_STATUS, 32'hffffffff, 32'h0, RESP_OKAY);
        rchk(REG_CTRL, 32'hffffffff, 32'h0, RESP_OKAY);
        rchk(8'h20, 32'hffffffff, 32'h0, RESP_SLVERR);
        wr(8'h24, 32'h1, RESP_SLVERR);
        $display("test registers done");
        wr(REG_VPP, 32'h1, RESP_OKAY);
        repeat (8) @(posedge aclk);
        rchk(REG_VPP, 32'h3, 32'h3, RESP_OKAY);
        wr(REG_DATA, 32'hff, RESP_OKAY);
        op({29'h0, OP_WRITE}, 32'h7, 32'h2);
        $display("test voltage and write done");
        wr(REG_ADDR, 32'h00123, RESP_OKAY);
        wr(REG_DATA, 32'h5a, RESP_OKAY);
        op({29'h0, OP_PROG}, FM, st(8'h5a, 1'b0));
        wr(REG_ADDR, 32'h05000, RESP_OKAY);
        wr(REG_DATA, 32'h3c, RESP_OKAY);
        op({29'h0, OP_PROG}, FM, st(8'h3c, 1'b0));
        wr(REG_ADDR, 32'h00123, RESP_OKAY);
        op(32'h0a, FM, st(8'h5a, 1'b0));
        $display("test program done");
        wr(REG_MASK, 32'h3, RESP_OKAY);
        op({29'h0, OP_BLOCK}, FM, st(8'hff, 1'b0));
        op({29'h0, OP_READ}, FM, st(8'hff, 1'b0));
        wr(REG_ADDR, 32'h05000, RESP_OKAY);
        op({29'h0, OP_READ}, FM, st(8'h3c, 1'b0));
        $display("test block erase done");
        op({29'h0, OP_CHIP}, FM, st(8'hff, 1'b0));
        op({29'h0, OP_READ}, FM, st(8'hff, 1'b0));
        $display("test chip erase done");
        wr(REG_MASK, 32'h0, RESP_OKAY);
        op({29'h0, OP_BLOCK}, 32'h7, 32'h6);
        op(32'h7, 32'h7, 32'h6);
        $display("test refusals done");
        give_verdict();
    end
endmodule : fps_host_ctrl_tb_top
